// ===== pkg/tcc_pkg.sv
/*
  constants for the type-c cc status and control register bank: register
  offsets, field positions, reset values, field encodings and toggle timing.
  assumes a 20 MHz device clock; no imports, users write tcc_pkg::name.
*/
package tcc_pkg;
  // register offsets on the byte register port
  localparam logic [7:0] ADDR_CONN_STATUS = 8'h08; // connection_status
  localparam logic [7:0] ADDR_PORT_STATUS_CTRL = 8'h09; // port_status_control
  localparam logic [7:0] ADDR_GENERAL_CTRL = 8'h0A; // general_control
  // reset values
  localparam logic [7:0] RST_CONN_STATUS = 8'h00;
  localparam logic [7:0] RST_PORT_STATUS_CTRL = 8'h20;
  localparam logic [7:0] RST_GENERAL_CTRL = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00; // unmapped read value
  // port_status_control field positions
  localparam int PSC_ATTACH_LSB = 6;
  localparam int PSC_ORIENT_BIT = 5;
  localparam int PSC_PENDING_BIT = 4;
  localparam int PSC_OVERCUR_BIT = 3;
  localparam int PSC_SHARE_LSB = 1;
  localparam int PSC_SINK_ACC_OFF_BIT = 0;
  // general_control field positions
  localparam int GC_SETTLE_LSB = 6;
  localparam int GC_ROLE_LSB = 4;
  localparam int GC_RESTART_BIT = 3;
  localparam int GC_PREF_LSB = 1;
  localparam int GC_TERM_OFF_BIT = 0;
  // connection_status field positions
  localparam int CS_ACC_LSB = 1;
  localparam int CS_CABLE_BIT = 0;
  // reset values of single fields
  localparam logic ORIENT_RST = 1'b1; // cc2
  localparam logic CABLE_RST = 1'b0;
  // attach_result encodings
  typedef enum logic [1:0] {
    ATT_NONE = 2'h0,
    ATT_SOURCE = 2'h1,
    ATT_SINK = 2'h2,
    ATT_ACCESSORY = 2'h3
  } tcc_attach_e;
  // accessory type encodings
  localparam logic [2:0] ACC_NONE = 3'h0;
  localparam logic [2:0] ACC_AUDIO = 3'h4;
  localparam logic [2:0] ACC_AUDIO_CHG = 3'h5;
  localparam logic [2:0] ACC_DEBUG_DFP = 3'h6;
  localparam logic [2:0] ACC_DEBUG_UFP = 3'h7;
  // port_role_setting encodings
  localparam logic [1:0] ROLE_DRP = 2'h0;
  localparam logic [1:0] ROLE_SINK = 2'h1;
  localparam logic [1:0] ROLE_SOURCE = 2'h2;
  localparam logic [1:0] ROLE_DRP_ALT = 2'h3;
  // toggle timing
  localparam int CLK_HZ = 20000000;
  localparam int TOGGLE_PERIOD_US = 100; // toggle_period, plain default
  localparam int TOGGLE_CYC = TOGGLE_PERIOD_US * (CLK_HZ / 1000000);
  localparam int SHARE_PCT_0 = 30;
  localparam int SHARE_PCT_1 = 40;
  localparam int SHARE_PCT_2 = 50;
  localparam int SHARE_PCT_3 = 60;
  localparam int TGL_CNT_W = 12;
  localparam logic [TGL_CNT_W-1:0] TGL_LAST = TGL_CNT_W'(TOGGLE_CYC - 1);
  localparam logic [TGL_CNT_W-1:0] TGL_SRC_0 = TGL_CNT_W'(TOGGLE_CYC * SHARE_PCT_0 / 100);
  localparam logic [TGL_CNT_W-1:0] TGL_SRC_1 = TGL_CNT_W'(TOGGLE_CYC * SHARE_PCT_1 / 100);
  localparam logic [TGL_CNT_W-1:0] TGL_SRC_2 = TGL_CNT_W'(TOGGLE_CYC * SHARE_PCT_2 / 100);
  localparam logic [TGL_CNT_W-1:0] TGL_SRC_3 = TGL_CNT_W'(TOGGLE_CYC * SHARE_PCT_3 / 100);
endpackage

// ===== verilog/tcc_toggle.sv
/*
  dual-role toggle timer: splits each toggle period into a source-advertise
  share and a sink share. assumes role and share come from flip-flops.
*/
`timescale 1ns/1ns
module tcc_toggle (
  input wire logic sys_clk_i, // device clock
  input wire logic nrst_i, // async reset, active low
  input wire logic enable_i, // high while the cc machine runs
  input wire logic [1:0] role_i, // effective port role
  input wire logic [1:0] share_i, // toggle_source_share
  output logic adv_source_o // high while advertising as source
);
  logic [tcc_pkg::TGL_CNT_W-1:0] cnt_ff; // position inside the period
  logic [tcc_pkg::TGL_CNT_W-1:0] src_len; // cycles spent as source
  logic adv_source_ff;

  // period counter, held at zero while disabled so a new period starts clean
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= '0;
    end else if (!enable_i || cnt_ff == tcc_pkg::TGL_LAST) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // share lookup
  always_comb begin
    case (share_i)
      2'h0: src_len = tcc_pkg::TGL_SRC_0; // 30 percent
      2'h1: src_len = tcc_pkg::TGL_SRC_1; // 40 percent
      2'h2: src_len = tcc_pkg::TGL_SRC_2; // 50 percent
      2'h3: src_len = tcc_pkg::TGL_SRC_3; // 60 percent
      default: src_len = tcc_pkg::TGL_SRC_0;
    endcase
  end

  // advertise source first in each period, then sink
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      adv_source_ff <= 1'b0;
    end else if (!enable_i) begin
      adv_source_ff <= 1'b0; // disabled: no advertising at all
    end else begin
      case (role_i)
        tcc_pkg::ROLE_SINK: adv_source_ff <= 1'b0;
        tcc_pkg::ROLE_SOURCE: adv_source_ff <= 1'b1;
        default: adv_source_ff <= (cnt_ff < src_len);
      endcase
    end
  end

  assign adv_source_o = adv_source_ff;
endmodule

// ===== verilog/tcc_status_control_regs.sv
/*
  type-c cc status and control register bank with a simple byte register
  port (the serial framing in front of it lives elsewhere). detection results
  arrive as levels from the cc analog front end, synchronous to sys_clk_i.
*/
// Summary of operation
// - accessory type in 3-bit field, 000 none
// - cable flag follows active cable, zero after reset
// - attach_result encodes none, source, sink, accessory
// - orientation bit: 0 cc1, 1 cc2, reset 1
// - change_irq_n low while change_pending is one
// - change_pending holds until software clears it
// - overcurrent sets sticky fault, asserts interrupt, clearable
// - source share per toggle period from selector
// - sink_accessory_off blocks accessories in sink role and debug ufp in any role
// - general control fields and 0x00 reset value
// - port status control resets to 0x20
// - logic_restart resets detection state, self-clears
// - port role selection, honoured only in serial mode
// - termination_off removes termination, disables cc machine
`timescale 1ns/1ns
module tcc_status_control_regs (
  input wire logic sys_clk_i, // device clock, 20 MHz
  input wire logic nrst_i, // async reset, active low
  input wire logic [7:0] reg_addr_i, // register offset
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe, one cycle
  input wire logic reg_rd_i, // read strobe, one cycle
  input wire logic serial_mode_i, // high when configured for serial control
  input wire logic [1:0] det_attach_i, // detected attach result
  input wire logic [2:0] det_accessory_i, // detected accessory type
  input wire logic det_cable_i, // active cable present
  input wire logic det_orient_i, // detected orientation, 1 = cc2
  input wire logic overcurrent_i, // cable-supply current limit tripped
  output logic [7:0] reg_rdata_o, // read data, valid cycle after strobe
  output logic change_irq_n_o, // interrupt, active low
  output logic term_enable_o, // cc termination applied
  output logic adv_source_o, // advertising as source
  output logic cc_restart_o, // one-cycle restart pulse to cc logic
  output logic [1:0] role_o, // effective port role
  output logic [1:0] role_pref_o, // role_preference to cc logic
  output logic [1:0] settle_sel_o, // cc_settle_time to cc logic
  output logic sink_acc_off_o // sink accessory support disabled
);
  // hardware-updated status
  logic [1:0] attach_ff; // attach_result
  logic [2:0] accessory_ff; // accessory type
  logic cable_ff; // powered_cable_seen
  logic orient_ff; // plug_orientation
  logic overcur_ff; // cable_supply_overcurrent
  logic pending_ff; // change_pending
  // software control
  logic [1:0] share_ff; // toggle_source_share
  logic sink_acc_off_ff; // sink_accessory_off
  logic [1:0] settle_ff; // cc_settle_time
  logic [1:0] role_set_ff; // port_role_setting
  logic restart_ff; // logic_restart, self-clearing
  logic [1:0] pref_ff; // role_preference
  logic term_off_ff; // termination_off
  // port outputs held in flip-flops
  logic [7:0] rdata_ff;
  logic irq_n_ff;
  // next values
  logic [1:0] nxt_attach;
  logic [2:0] nxt_accessory;
  logic nxt_cable;
  logic nxt_orient;
  logic nxt_overcur;
  logic nxt_pending;
  logic [1:0] nxt_role;
  logic wr_psc; // write to port_status_control
  logic wr_gc; // write to general_control
  logic acc_blocked; // accessory report suppressed
  logic changed; // any register value but change_pending and the restart self-clear moves this cycle
  logic [7:0] cs_val;
  logic [7:0] psc_val;
  logic [7:0] gc_val;
  logic adv_source_w;

  assign wr_psc = reg_wr_i && (reg_addr_i == tcc_pkg::ADDR_PORT_STATUS_CTRL);
  assign wr_gc = reg_wr_i && (reg_addr_i == tcc_pkg::ADDR_GENERAL_CTRL);

  // the role field only counts under serial control; pin mode runs dual-role
  assign nxt_role = serial_mode_i ? role_set_ff : tcc_pkg::ROLE_DRP;

  // accessories seen while sinking, and debug ufp accessories in any role, are dropped when support is switched off
  assign acc_blocked = sink_acc_off_ff && ((nxt_role == tcc_pkg::ROLE_SINK) ||
                       (det_accessory_i == tcc_pkg::ACC_DEBUG_UFP));

  // next detection status; restart and disabled cc machine force defaults
  always_comb begin
    nxt_attach = det_attach_i;
    nxt_accessory = det_accessory_i;
    nxt_cable = det_cable_i;
    nxt_orient = det_orient_i;
    if (restart_ff || term_off_ff) begin
      nxt_attach = tcc_pkg::ATT_NONE;
      nxt_accessory = tcc_pkg::ACC_NONE;
      nxt_cable = tcc_pkg::CABLE_RST;
      nxt_orient = tcc_pkg::ORIENT_RST;
    end else if (acc_blocked) begin
      nxt_accessory = tcc_pkg::ACC_NONE;
      if (det_attach_i == tcc_pkg::ATT_ACCESSORY) begin
        nxt_attach = tcc_pkg::ATT_NONE;
      end
    end
  end

  // fault is sticky; a trip in the clearing cycle keeps it set
  assign nxt_overcur = overcurrent_i ||
    (overcur_ff && !(wr_psc && reg_wdata_i[tcc_pkg::PSC_OVERCUR_BIT]));

  // any change of a stored value other than the pending bit itself and the restart self-clear
  assign changed = (nxt_attach != attach_ff) || (nxt_accessory != accessory_ff) ||
    (nxt_cable != cable_ff) || (nxt_orient != orient_ff) ||
    (nxt_overcur != overcur_ff) ||
    (wr_psc && (reg_wdata_i[2:0] != {share_ff, sink_acc_off_ff})) ||
    (wr_gc && (reg_wdata_i != gc_val));

  // pending: set wins over the write-one clear
  assign nxt_pending = changed ||
    (pending_ff && !(wr_psc && reg_wdata_i[tcc_pkg::PSC_PENDING_BIT]));

  // hardware-only status; the register port never writes these
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      attach_ff <= tcc_pkg::ATT_NONE;
      accessory_ff <= tcc_pkg::ACC_NONE;
      cable_ff <= tcc_pkg::CABLE_RST;
      orient_ff <= tcc_pkg::ORIENT_RST;
    end else begin
      attach_ff <= nxt_attach;
      accessory_ff <= nxt_accessory;
      cable_ff <= nxt_cable;
      orient_ff <= nxt_orient;
    end
  end

  // sticky fault and change flag
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      overcur_ff <= 1'b0;
      pending_ff <= 1'b0;
    end else begin
      overcur_ff <= nxt_overcur;
      pending_ff <= nxt_pending;
    end
  end

  // software fields of port_status_control
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      share_ff <= 2'h0;
      sink_acc_off_ff <= 1'b0;
    end else if (wr_psc) begin
      share_ff <= reg_wdata_i[tcc_pkg::PSC_SHARE_LSB +: 2];
      sink_acc_off_ff <= reg_wdata_i[tcc_pkg::PSC_SINK_ACC_OFF_BIT];
    end
  end

  // general_control; the restart bit lives for one cycle only
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      settle_ff <= 2'h0;
      role_set_ff <= 2'h0;
      pref_ff <= 2'h0;
      term_off_ff <= 1'b0;
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= wr_gc && reg_wdata_i[tcc_pkg::GC_RESTART_BIT];
      if (wr_gc) begin
        settle_ff <= reg_wdata_i[tcc_pkg::GC_SETTLE_LSB +: 2];
        role_set_ff <= reg_wdata_i[tcc_pkg::GC_ROLE_LSB +: 2];
        pref_ff <= reg_wdata_i[tcc_pkg::GC_PREF_LSB +: 2];
        term_off_ff <= reg_wdata_i[tcc_pkg::GC_TERM_OFF_BIT];
      end
    end
  end

  // register images
  always_comb begin
    cs_val = tcc_pkg::RST_CONN_STATUS;
    cs_val[tcc_pkg::CS_ACC_LSB +: 3] = accessory_ff;
    cs_val[tcc_pkg::CS_CABLE_BIT] = cable_ff;
    psc_val = {attach_ff, orient_ff, pending_ff, overcur_ff, share_ff,
               sink_acc_off_ff};
    gc_val = {settle_ff, role_set_ff, restart_ff, pref_ff, term_off_ff};
  end

  // read port; unmapped offsets read as zero
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= tcc_pkg::BYTE_ZERO;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        tcc_pkg::ADDR_CONN_STATUS: rdata_ff <= cs_val;
        tcc_pkg::ADDR_PORT_STATUS_CTRL: rdata_ff <= psc_val;
        tcc_pkg::ADDR_GENERAL_CTRL: rdata_ff <= gc_val;
        default: rdata_ff <= tcc_pkg::BYTE_ZERO;
      endcase
    end
  end

  // interrupt moves on the same edge as the flags, taken from their next values
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_n_ff <= 1'b1;
    end else begin
      irq_n_ff <= !(nxt_pending || nxt_overcur);
    end
  end

  // toggle timer runs only while termination is applied and not restarting
  tcc_toggle u_toggle (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .enable_i(!term_off_ff && !restart_ff),
    .role_i(nxt_role),
    .share_i(share_ff),
    .adv_source_o(adv_source_w)
  );

  // registered control outputs
  logic term_en_ff;
  logic [1:0] role_ff;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      term_en_ff <= 1'b1;
      role_ff <= tcc_pkg::ROLE_DRP;
    end else begin
      term_en_ff <= !term_off_ff;
      role_ff <= nxt_role;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign change_irq_n_o = irq_n_ff;
  assign term_enable_o = term_en_ff;
  assign adv_source_o = adv_source_w;
  assign cc_restart_o = restart_ff;
  assign role_o = role_ff;
  assign role_pref_o = pref_ff;
  assign settle_sel_o = settle_ff;
  assign sink_acc_off_o = sink_acc_off_ff;
endmodule

// ===== verification/tcc_regs_checker.sv
/*
  concurrent checks on the cc status and control bank ports, bound into
  the top module. assumes one clock domain and one-cycle strobes.
*/
`timescale 1ns/1ns
module tcc_regs_checker (
  input wire logic sys_clk_i, // clock
  input wire logic nrst_i, // reset, active low
  input wire logic [7:0] reg_addr_i, // offset
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  input wire logic serial_mode_i, // serial control
  input wire logic det_cable_i, // cable seen
  input wire logic overcurrent_i, // supply trip
  input wire logic [7:0] reg_rdata_o, // read data
  input wire logic change_irq_n_o, // irq, low
  input wire logic term_enable_o, // termination
  input wire logic adv_source_o, // source advert
  input wire logic cc_restart_o, // restart pulse
  input wire logic [1:0] role_o, // role
  input wire logic [1:0] role_pref_o, // preference
  input wire logic [1:0] settle_sel_o // settle select
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic wr_gc; // write to general_control
  logic wr_psc; // write to port_status_control
  assign wr_gc = reg_wr_i && reg_addr_i == tcc_pkg::ADDR_GENERAL_CTRL;
  assign wr_psc = reg_wr_i && reg_addr_i == tcc_pkg::ADDR_PORT_STATUS_CTRL;
  // a lone write, so fields are settled two edges on
  sequence s_gc_lone;
    wr_gc ##1 !reg_wr_i;
  endsequence
  // a control write just before may mask detection, so it is excluded
  AST_CABLE_IRQ: assert property ($changed(det_cable_i) && term_enable_o && !wr_gc
    && !$past(wr_gc) |=> !change_irq_n_o) else $error("cable change left irq high");
  AST_IRQ_HOLD: assert property (!change_irq_n_o && !wr_psc |=> !change_irq_n_o)
    else $error("irq released without clear");
  AST_FAULT_IRQ: assert property (overcurrent_i |=> !change_irq_n_o)
    else $error("fault did not pull irq low");
  AST_RESTART_ONE: assert property (cc_restart_o |=> !cc_restart_o)
    else $error("restart pulse longer than one cycle");
  AST_RESTART_CAUSE: assert property (wr_gc && reg_wdata_i[3] |-> ##[1:2] cc_restart_o)
    else $error("restart write gave no pulse");
  AST_TERM: assert property (s_gc_lone |=> term_enable_o == !$past(reg_wdata_i[0], 2))
    else $error("termination does not follow control");
  AST_CTRL_OUT: assert property (s_gc_lone |=> settle_sel_o == $past(reg_wdata_i[7:6], 2)
    && role_pref_o == $past(reg_wdata_i[2:1], 2)) else $error("control fields not driven");
  AST_ROLE_FORCE: assert property ((!serial_mode_i)[*3] |-> role_o == tcc_pkg::ROLE_DRP)
    else $error("role not forced outside serial mode");
  AST_SRC_ONLY: assert property ((term_enable_o && !cc_restart_o
    && role_o == tcc_pkg::ROLE_SOURCE)[*3] |-> adv_source_o) else $error("source role idle");
  AST_SINK_ONLY: assert property ((role_o == tcc_pkg::ROLE_SINK)[*3] |-> !adv_source_o)
    else $error("sink role advertised source");
  AST_TERM_ADV: assert property ((!term_enable_o)[*3] |-> !adv_source_o)
    else $error("advertising with termination off");
endmodule
bind tcc_status_control_regs tcc_regs_checker u_chk (.sys_clk_i, .nrst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .serial_mode_i, .det_cable_i, .overcurrent_i,
  .reg_rdata_o, .change_irq_n_o, .term_enable_o, .adv_source_o, .cc_restart_o, .role_o,
  .role_pref_o, .settle_sel_o);

// ===== verification/tcc_cc_partner.sv
/*
  model of the type-c partner as seen through the cc front end: detection
  levels and supply trips. assumes the bench calls its tasks in sequence.
*/
`timescale 1ns/1ns
module tcc_cc_partner (
  input wire logic sys_clk_i, // device clock
  output logic [1:0] det_attach_o, // attach result
  output logic [2:0] det_accessory_o, // accessory code
  output logic det_cable_o, // active cable
  output logic det_orient_o, // 1 = cc2
  output logic overcurrent_o // supply trip
);
  // idle matches the reset state, so release of reset raises no event
  initial begin
    {det_attach_o, det_accessory_o, det_cable_o, det_orient_o} = 7'h01;
    overcurrent_o = 1'b0;
  end
  // state is {attach, accessory, cable, orientation}, held as a level
  task automatic plug(input logic [6:0] s);
    @(posedge sys_clk_i);
    {det_attach_o, det_accessory_o, det_cable_o, det_orient_o} <= s;
  endtask
  // one-cycle trip: the shortest event, so a level-only latch would miss it
  task automatic trip();
    @(posedge sys_clk_i);
    overcurrent_o <= 1'b1;
    @(posedge sys_clk_i);
    overcurrent_o <= 1'b0;
  endtask
endmodule

// ===== verification/test_tcc_status_control_regs.sv
/*
  self-checking bench for the cc status and control bank over its byte
  register port. assumes the partner model drives the detection levels.
*/
`timescale 1ns/1ns
module test_tcc_status_control_regs;
  logic sys_clk_i = 1'b0; // 20 MHz clock
  logic nrst_i = 1'b0; // reset, active low
  logic [7:0] reg_addr_i = 8'h00; // offset
  logic [7:0] reg_wdata_i = 8'h00; // write data
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, serial_mode_i = 1'b1; // strobes, mode
  logic [1:0] det_attach_i, role_o, role_pref_o, settle_sel_o; // detection, control
  logic [2:0] det_accessory_i; // accessory code
  logic det_cable_i, det_orient_i, overcurrent_i; // partner levels
  logic [7:0] reg_rdata_o; // read data
  logic change_irq_n_o, term_enable_o, adv_source_o, cc_restart_o, sink_acc_off_o;
  int failures = 0, num_checks = 0, cyc = 0, n;
  // {attach, accessory, cable, orientation}: every attach code but none, every accessory code
  logic [6:0] tbl [6] = '{7'h22, 7'h41, 7'h70, 7'h75, 7'h7A, 7'h7D};
  tcc_status_control_regs dut (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .serial_mode_i, .det_attach_i, .det_accessory_i, .det_cable_i, .det_orient_i,
    .overcurrent_i, .reg_rdata_o, .change_irq_n_o, .term_enable_o, .adv_source_o,
    .cc_restart_o, .role_o, .role_pref_o, .settle_sel_o, .sink_acc_off_o);
  tcc_cc_partner u_partner (.sys_clk_i, .det_attach_o(det_attach_i),
    .det_accessory_o(det_accessory_i), .det_cable_o(det_cable_i),
    .det_orient_o(det_orient_i), .overcurrent_o(overcurrent_i));
  always #25 sys_clk_i = ~sys_clk_i;
  task automatic test_done();
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  // strobe held exactly one edge, as the port takes one byte per pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // data is looked at mid-cycle, after the answering edge has landed
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk({8'h00, reg_rdata_o}, {8'h00, e});
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge sys_clk_i);
  endtask
  // cuts a hang short; the run needs some 16200 cycles
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    idle(2);
    rdc(8'h08, 8'h00);
    rdc(8'h09, 8'h20);
    rdc(8'h0A, 8'h00);
    rdc(8'h0B, 8'h00);
    wr(8'h08, 8'hFF);
    wr(8'h09, 8'hE0);
    rdc(8'h08, 8'h00);
    rdc(8'h09, 8'h20);
    chkb(change_irq_n_o, 1'b1);
    foreach (tbl[i]) begin
      u_partner.plug(tbl[i]);
      idle(3);
      rdc(8'h08, {4'h0, tbl[i][4:1]});
      rdc(8'h09, {tbl[i][6:5], tbl[i][0], 5'h10});
      chkb(change_irq_n_o, 1'b0);
      wr(8'h09, 8'h10);
      rdc(8'h09, {tbl[i][6:5], tbl[i][0], 5'h00});
      chkb(change_irq_n_o, 1'b1);
    end
    wr(8'h09, 8'h01);
    idle(3);
    rdc(8'h08, 8'h00);
    rdc(8'h09, 8'h31);
    chkb(sink_acc_off_o, 1'b1);
    wr(8'h09, 8'h10);
    idle(3);
    wr(8'h09, 8'h10);
    rdc(8'h09, 8'hE0);
    u_partner.plug(7'h01);
    u_partner.trip();
    idle(3);
    rdc(8'h09, 8'h38);
    chkb(change_irq_n_o, 1'b0);
    wr(8'h09, 8'h18);
    rdc(8'h09, 8'h30);
    wr(8'h09, 8'h10);
    rdc(8'h09, 8'h20);
    wr(8'h0A, 8'hF6);
    rdc(8'h0A, 8'hF6);
    chk({14'h0, role_o}, 16'h0003);
    chk({12'h0, settle_sel_o, role_pref_o}, 16'h000F);
    wr(8'h0A, 8'hFE);
    // the restart pulse stands for the single cycle after the write edge
    idle(1);
    chkb(cc_restart_o, 1'b1);
    idle(2);
    chkb(cc_restart_o, 1'b0);
    rdc(8'h0A, 8'hF6);
    wr(8'h0A, 8'h10);
    idle(4);
    chk({14'h0, role_o}, 16'h0001);
    @(posedge sys_clk_i);
    serial_mode_i <= 1'b0;
    idle(4);
    chk({14'h0, role_o}, 16'h0000);
    @(posedge sys_clk_i);
    serial_mode_i <= 1'b1;
    wr(8'h0A, 8'h20);
    idle(4);
    chkb(adv_source_o, 1'b1);
    // a live attach, so the disabled machine has something to hide
    u_partner.plug(7'h22);
    wr(8'h0A, 8'h21);
    idle(4);
    chkb(term_enable_o, 1'b0);
    chkb(adv_source_o, 1'b0);
    rdc(8'h08, 8'h00);
    rdc(8'h09, 8'h30);
    wr(8'h0A, 8'h00);
    // any full period window holds exactly one source share
    for (int s = 0; s < 4; s++) begin
      wr(8'h09, 8'(s * 2));
      idle(tcc_pkg::TOGGLE_CYC);
      n = 0;
      repeat (tcc_pkg::TOGGLE_CYC) begin
        @(negedge sys_clk_i);
        if (adv_source_o === 1'b1) n++;
      end
      chk(16'(n), 16'(tcc_pkg::TOGGLE_CYC * (30 + 10 * s) / 100));
    end
    test_done();
  end
endmodule
